// ### hw/vtcf_regs.svh
// register offsets, reset values and field positions of the vlan classifier
`ifndef VTCF_REGS_SVH
`define VTCF_REGS_SVH
`define VTCF_CTRL 12'h000
`define VTCF_STATUS 12'h004
`define VTCF_DFLT_SEL 12'h008
`define VTCF_DFLT_VID 12'h00C
`define VTCF_VT_SEL 12'h010
`define VTCF_VT_VID 12'h014
`define VTCF_VT_MEMBER 12'h018
`define VTCF_VT_UNTAG 12'h01C
`define VTCF_RT_SEL 12'h020
`define VTCF_RT_NET 12'h024
`define VTCF_RT_MASK 12'h028
`define VTCF_RT_VIF 12'h02C
`define VTCF_VIF_VID 12'h030
`define VTCF_DEF_VID 12'h001
`define VTCF_VALID_BIT 12
`define VTCF_GROUP_BIT 40
`endif

// ### hw/vtcf_pkg.sv
// shared types of the vlan classifier
`default_nettype none
package vtcf_pkg;
  typedef logic [11:0] vtcf_vid_t;
  typedef logic [47:0] vtcf_mac_t;
endpackage
`default_nettype wire

// ### hw/vtcf_top.sv
// vlan classification, membership, learning and tag handling engine
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vtcf_regs.svh"
module vtcf_top import vtcf_pkg::*; #(
  parameter int NPORT = 8,
  parameter int SLOTS = 128,
  parameter int MACS = 16,
  parameter int ROUTES = 8,
  parameter int VIFS = 4
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // received frame descriptor, same clock
  input wire logic RX_VALID,
  input wire logic [$clog2(NPORT)-1:0] RX_PORT,
  input wire logic RX_TAGGED,
  input wire vtcf_vid_t RX_VID,
  input wire vtcf_mac_t RX_DA,
  input wire vtcf_mac_t RX_SA,
  input wire logic RX_JOIN,
  // forwarding decision
  output logic TX_VALID,
  output logic [NPORT-1:0] TX_MASK,
  output logic [NPORT-1:0] TX_UNTAG_MASK,
  output logic [NPORT-1:0] TX_TAGGED_MASK,
  output vtcf_vid_t TX_VID,
  output logic TX_JOIN_RELAY
);
  localparam int PW = $clog2(NPORT);
  localparam int SW = $clog2(SLOTS);
  localparam int MW = $clog2(MACS);
  localparam int RW = $clog2(ROUTES);
  localparam int VW = $clog2(VIFS);
  typedef struct packed {
    logic ml;
    logic refused;
    logic [PW-1:0] dflt_sel;
    logic [NPORT-1:0][11:0] dflt_vid;
    logic [SW-1:0] vt_sel;
    logic [SLOTS-1:0] vt_valid;
    logic [SLOTS-1:0][11:0] vt_vid;
    logic [SLOTS-1:0][NPORT-1:0] vt_mem, vt_untag;
    logic [MACS-1:0] mac_valid;
    logic [MACS-1:0][47:0] mac_addr;
    logic [MACS-1:0][PW-1:0] mac_port;
    logic [MW-1:0] mac_ptr;
    logic [RW-1:0] rt_sel;
    logic [ROUTES-1:0][31:0] rt_net, rt_mask;
    logic [ROUTES-1:0][VW-1:0] rt_vif;
    logic [VIFS-1:0][11:0] vif_vid;
    logic pready, pslverr, tx_valid, tx_join;
    logic [31:0] prdata;
    logic [NPORT-1:0] tx_mask, tx_untag, tx_tagged;
    logic [11:0] tx_vid;
  } vtcf_state_t;
  // reset image: all defaults 1, slot 0 is vlan 1 with every port untagged
  function automatic vtcf_state_t rst_val();
    vtcf_state_t s;
    s = '0;
    s.dflt_vid = {NPORT{`VTCF_DEF_VID}};
    s.vt_valid[0] = 1'b1;
    s.vt_vid[0] = `VTCF_DEF_VID;
    s.vt_mem[0] = '1;
    s.vt_untag[0] = '1;
    return s;
  endfunction
  localparam vtcf_state_t RST_ST = rst_val();
  // live high: slot holding a vid; live low: lowest empty slot; {found, slot}
  function automatic logic [SW:0] find_vid(vtcf_state_t s, vtcf_vid_t v, logic live);
    logic [SW:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (s.vt_valid[i] == live && (!live || s.vt_vid[i] == v)) r = {1'b1, SW'(i)};
    end
    return r;
  endfunction
  // ports that are members of any valid slot other than k
  function automatic logic [NPORT-1:0] elsewhere(vtcf_state_t s, logic [SW-1:0] k);
    logic [NPORT-1:0] m;
    m = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (s.vt_valid[i] && SW'(i) != k) m = m | s.vt_mem[i];
    end
    return m;
  endfunction
  // learned entry for a mac: {hit, index}
  function automatic logic [MW:0] find_mac(vtcf_state_t s, vtcf_mac_t a);
    logic [MW:0] r;
    r = '0;
    for (int i = MACS - 1; i >= 0; i--) begin
      if (s.mac_valid[i] && s.mac_addr[i] == a) r = {1'b1, MW'(i)};
    end
    return r;
  endfunction
  vtcf_state_t q, d;
  vtcf_vid_t cls_vid;
  logic [SW:0] cls, free;
  logic [MW:0] da_f, sa_f;
  logic [NPORT-1:0] others, els_sel, els_cls;

  // classification from port default or tag; free is the lowest empty slot
  assign cls_vid = RX_TAGGED ? RX_VID : q.dflt_vid[RX_PORT];
  assign cls = find_vid(q, RX_JOIN ? RX_VID : cls_vid, 1'b1);
  assign free = find_vid(q, 12'h000, 1'b0);
  assign da_f = find_mac(q, RX_DA);
  assign sa_f = find_mac(q, RX_SA);
  assign others = ~(NPORT'(1) << RX_PORT);
  assign els_sel = elsewhere(q, q.vt_sel);
  assign els_cls = elsewhere(q, cls[SW-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic acc, hit;
    logic [31:0] rd;
    logic [NPORT-1:0] want, dest;
    logic [SW-1:0] js;
    logic [7:0] used;
    acc = PSEL && PENABLE;
    rd = '0;
    hit = 1'b1;
    want = PWDATA[NPORT-1:0];
    dest = '0;
    js = '0;
    used = '0;
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.tx_valid = 1'b0;
    d.tx_join = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      used = used + 8'(q.vt_valid[i]);
    end
    // read mux and decode
    case (PADDR)
      `VTCF_CTRL: rd = 32'(q.ml);
      `VTCF_STATUS: rd = {16'h0000, used, 7'h00, q.refused};
      `VTCF_DFLT_SEL: rd = 32'(q.dflt_sel);
      `VTCF_DFLT_VID: rd = 32'(q.dflt_vid[q.dflt_sel]);
      `VTCF_VT_SEL: rd = 32'(q.vt_sel);
      `VTCF_VT_VID: rd = 32'({q.vt_valid[q.vt_sel], q.vt_vid[q.vt_sel]});
      `VTCF_VT_MEMBER: rd = 32'(q.vt_mem[q.vt_sel]);
      `VTCF_VT_UNTAG: rd = 32'(q.vt_untag[q.vt_sel]);
      `VTCF_RT_SEL: rd = 32'(q.rt_sel);
      `VTCF_RT_NET: rd = q.rt_net[q.rt_sel];
      `VTCF_RT_MASK: rd = q.rt_mask[q.rt_sel];
      `VTCF_RT_VIF: rd = 32'(q.rt_vif[q.rt_sel]);
      `VTCF_VIF_VID: rd = 32'(q.vif_vid[VW'(q.rt_sel)]);
      default: hit = 1'b0;
    endcase
    // one wait state, then answer
    if (acc && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = PWRITE ? 32'h00000000 : rd;
      d.pslverr = !hit;
    end
    // writes land at the completing edge
    if (acc && q.pready && PWRITE) begin
      case (PADDR)
        `VTCF_CTRL: d.ml = PWDATA[0];
        `VTCF_STATUS: d.refused = q.refused && !PWDATA[0];
        `VTCF_DFLT_SEL: d.dflt_sel = PWDATA[PW-1:0];
        `VTCF_DFLT_VID: d.dflt_vid[q.dflt_sel] = PWDATA[11:0];
        `VTCF_VT_SEL: d.vt_sel = PWDATA[SW-1:0];
        `VTCF_VT_VID: {d.vt_valid[q.vt_sel], d.vt_vid[q.vt_sel]} = PWDATA[12:0];
        `VTCF_VT_MEMBER: begin
          // overlap refused in multilayer mode
          if (q.ml && |(want & els_sel)) begin
            want = want & ~els_sel;
            d.refused = 1'b1;
          end
          d.vt_mem[q.vt_sel] = want;
        end
        `VTCF_VT_UNTAG: d.vt_untag[q.vt_sel] = PWDATA[NPORT-1:0];
        `VTCF_RT_SEL: d.rt_sel = PWDATA[RW-1:0];
        `VTCF_RT_NET: d.rt_net[q.rt_sel] = PWDATA;
        `VTCF_RT_MASK: d.rt_mask[q.rt_sel] = PWDATA;
        `VTCF_RT_VIF: d.rt_vif[q.rt_sel] = PWDATA[VW-1:0];
        `VTCF_VIF_VID: d.vif_vid[VW'(q.rt_sel)] = PWDATA[11:0];
        default: ;
      endcase
    end
    // whole frame received: decide, learn, join
    if (RX_VALID) begin
      if (sa_f[MW]) begin
        d.mac_port[sa_f[MW-1:0]] = RX_PORT;
      end else begin
        d.mac_valid[q.mac_ptr] = 1'b1;
        d.mac_addr[q.mac_ptr] = RX_SA;
        d.mac_port[q.mac_ptr] = RX_PORT;
        d.mac_ptr = q.mac_ptr + MW'(1);
      end
      d.tx_valid = 1'b1;
      if (RX_JOIN) begin
        // join: add ingress port unless refused in multilayer mode or no slot is free, relay everywhere else
        js = cls[SW] ? cls[SW-1:0] : free[SW-1:0];
        if (q.ml && (els_cls[RX_PORT] || !cls[SW])) begin
          d.refused = 1'b1;
        end else if (cls[SW] || free[SW]) begin
          d.vt_valid[js] = 1'b1;
          d.vt_vid[js] = RX_VID;
          if (!cls[SW] || !q.vt_mem[js][RX_PORT]) d.vt_untag[js][RX_PORT] = 1'b0;
          if (!cls[SW]) d.vt_mem[js] = '0;
          if (!cls[SW]) d.vt_untag[js] = '0;
          d.vt_mem[js][RX_PORT] = 1'b1;
        end
        d.tx_join = 1'b1;
        d.tx_mask = others;
        d.tx_untag = '0;
        d.tx_tagged = '0;
        d.tx_vid = RX_VID;
      end else begin
        // unknown vlan keeps dest empty
        if (cls[SW] && da_f[MW] && !RX_DA[`VTCF_GROUP_BIT]
            && q.vt_mem[cls[SW-1:0]][q.mac_port[da_f[MW-1:0]]]) begin
          dest = (NPORT'(1) << q.mac_port[da_f[MW-1:0]]) & others;
        end else if (cls[SW]) begin
          dest = q.vt_mem[cls[SW-1:0]] & others;
        end
        d.tx_mask = dest;
        d.tx_untag = dest & q.vt_untag[cls[SW-1:0]];
        d.tx_tagged = dest & ~q.vt_untag[cls[SW-1:0]];
        d.tx_vid = cls_vid;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= RST_ST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign PREADY = q.pready;
  assign PRDATA = q.prdata;
  assign PSLVERR = q.pslverr;
  assign TX_VALID = q.tx_valid;
  assign TX_MASK = q.tx_mask;
  assign TX_UNTAG_MASK = q.tx_untag;
  assign TX_TAGGED_MASK = q.tx_tagged;
  assign TX_VID = q.tx_vid;
  assign TX_JOIN_RELAY = q.tx_join;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [NPORT-1:0] cls_mem, cls_untag;
  assign cls_mem = cls[SW] ? q.vt_mem[cls[SW-1:0]] : '0;
  assign cls_untag = cls[SW] ? q.vt_untag[cls[SW-1:0]] : '0;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_plain_rx;
    RX_VALID && !RX_JOIN;
  endsequence
  sequence s_apb_wait;
    PSEL && PENABLE && !PREADY;
  endsequence

  property p_untagged_default;
    s_plain_rx and (!RX_TAGGED && cls[SW]) |=> TX_VALID && TX_VID == $past(q.dflt_vid[RX_PORT]);
  endproperty
  a_untagged_default: assert property (p_untagged_default) else $error("untagged frame not in default vlan");
  property p_tagged_vid;
    s_plain_rx and RX_TAGGED |=> TX_VID == $past(RX_VID);
  endproperty
  a_tagged_vid: assert property (p_tagged_vid) else $error("tagged frame vlan differs from tag");
  property p_strip;
    s_plain_rx |=> TX_UNTAG_MASK == (TX_MASK & $past(cls_untag));
  endproperty
  a_strip: assert property (p_strip) else $error("untagged egress ports wrong");
  property p_insert;
    s_plain_rx |=> (TX_TAGGED_MASK | TX_UNTAG_MASK) == TX_MASK && !(|(TX_TAGGED_MASK & TX_UNTAG_MASK));
  endproperty
  a_insert: assert property (p_insert) else $error("tag insert masks inconsistent");
  property p_member_only;
    s_plain_rx |=> !(|(TX_MASK & ~$past(cls_mem))) && !TX_MASK[$past(RX_PORT)];
  endproperty
  a_member_only: assert property (p_member_only) else $error("frame sent to non member port");
  property p_learn;
    RX_VALID |=> q.mac_valid[$past(sa_f[MW] ? sa_f[MW-1:0] : q.mac_ptr)]
      && q.mac_addr[$past(sa_f[MW] ? sa_f[MW-1:0] : q.mac_ptr)] == $past(RX_SA)
      && q.mac_port[$past(sa_f[MW] ? sa_f[MW-1:0] : q.mac_ptr)] == $past(RX_PORT);
  endproperty
  a_learn: assert property (p_learn) else $error("source mac not learned");
  property p_join_relay;
    RX_VALID && RX_JOIN |=> TX_JOIN_RELAY && TX_MASK == ~(NPORT'(1) << $past(RX_PORT));
  endproperty
  a_join_relay: assert property (p_join_relay) else $error("join not relayed to other ports");
  property p_join_add;
    RX_VALID && RX_JOIN && !q.ml && cls[SW] |=> q.vt_mem[$past(cls[SW-1:0])][$past(RX_PORT)];
  endproperty
  a_join_add: assert property (p_join_add) else $error("join did not add port");
  property p_ml_single;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == `VTCF_VT_MEMBER && q.ml
      |=> !(|(q.vt_mem[q.vt_sel] & els_sel));
  endproperty
  a_ml_single: assert property (p_ml_single) else $error("port overlap in multilayer mode");
  property p_store_fwd;
    TX_VALID |-> $past(RX_VALID);
  endproperty
  a_store_fwd: assert property (p_store_fwd) else $error("decision without a received frame");
  property p_apb_answer;
    s_apb_wait |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer not after one wait");
endmodule
`default_nettype wire

// ### verif/vtcf_station.sv
// station model that hands whole frame descriptors to the classifier
`timescale 1ns/1ps
`default_nettype none
module vtcf_station import vtcf_pkg::*; (
  // clock
  input wire logic clk,
  // frame descriptor towards the classifier
  output logic rx_valid,
  output logic [2:0] rx_port,
  output logic rx_tagged,
  output vtcf_vid_t rx_vid,
  output vtcf_mac_t rx_da,
  output vtcf_mac_t rx_sa,
  output logic rx_join
);
  // idle before the first frame
  initial begin
    rx_valid = 1'b0;
    rx_port = 3'h0;
    rx_tagged = 1'b0;
    rx_vid = 12'h000;
    rx_da = 48'h0;
    rx_sa = 48'h0;
    rx_join = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one descriptor per frame, handed over only once fully received
  task send(input logic [2:0] p, input logic t, input vtcf_vid_t v, input vtcf_mac_t da,
            input vtcf_mac_t sa, input logic j);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_port <= p;
    rx_tagged <= t;
    rx_vid <= v;
    rx_da <= da;
    rx_sa <= sa;
    rx_join <= j;
    @(posedge clk);
    // released fields show garbage, not the last frame
    rx_valid <= 1'b0;
    rx_port <= ~p;
    rx_tagged <= ~t;
    rx_vid <= ~v;
    rx_da <= ~da;
    rx_sa <= ~sa;
    rx_join <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ### verif/vlan_tag_classify_forward_tb_top.sv
// testbench of the vlan classifier: register access and forwarding decisions
`timescale 1ns/1ps
`default_nettype none
`include "vtcf_regs.svh"
module vlan_tag_classify_forward_tb_top;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  localparam logic [47:0] M0 = 48'h00000A000000;
  localparam logic [47:0] M1 = 48'h00000A000001;
  localparam logic [47:0] M2 = 48'h00000A000002;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_valid, rx_tagged, rx_join, tx_valid, tx_join_relay;
  logic [2:0] rx_port;
  logic [11:0] rx_vid, tx_vid;
  logic [47:0] rx_da, rx_sa;
  logic [7:0] tx_mask, tx_untag_mask, tx_tagged_mask;
  int mismatches = 0;
  int checks = 0;

  // device and far-side station
  vtcf_top i_dut (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .RX_VALID(rx_valid), .RX_PORT(rx_port), .RX_TAGGED(rx_tagged), .RX_VID(rx_vid), .RX_DA(rx_da),
    .RX_SA(rx_sa), .RX_JOIN(rx_join), .TX_VALID(tx_valid), .TX_MASK(tx_mask),
    .TX_UNTAG_MASK(tx_untag_mask), .TX_TAGGED_MASK(tx_tagged_mask), .TX_VID(tx_vid),
    .TX_JOIN_RELAY(tx_join_relay));
  vtcf_station i_sta (.clk(clk), .rx_valid(rx_valid), .rx_port(rx_port), .rx_tagged(rx_tagged),
    .rx_vid(rx_vid), .rx_da(rx_da), .rx_sa(rx_sa), .rx_join(rx_join));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // value comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // frame in, decision compared one cycle later
  task frm(input logic [2:0] p, input logic t, input logic [11:0] v, input logic [47:0] da,
           input logic [47:0] sa, input logic j, input logic [11:0] ev, input logic [7:0] em,
           input logic [7:0] eu, input logic [7:0] et);
    i_sta.send(p, t, v, da, sa, j);
    chk({18'h0, tx_valid, tx_join_relay, tx_vid}, {18'h0, 1'b1, j, ev});
    chk({8'h0, tx_mask, tx_untag_mask, tx_tagged_mask}, {8'h0, em, eu, et});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wr(`VTCF_DFLT_SEL, 32'h3);
    rdc(`VTCF_DFLT_VID, 32'h1);
    rdc(`VTCF_VT_VID, 32'h1001);
    rdc(`VTCF_VT_MEMBER, 32'hFF);
    rdc(`VTCF_VT_UNTAG, 32'hFF);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    frm(3'h2, 1'b0, 12'h0, BC, M0, 1'b0, 12'h001, 8'hFB, 8'hFB, 8'h00);
    wr(`VTCF_DFLT_SEL, 32'h2);
    wr(`VTCF_DFLT_VID, 32'h5);
    frm(3'h2, 1'b0, 12'h0, BC, M0, 1'b0, 12'h005, 8'h00, 8'h00, 8'h00);
    wr(`VTCF_VT_SEL, 32'h1);
    wr(`VTCF_VT_VID, 32'h1005);
    wr(`VTCF_VT_MEMBER, 32'h0F);
    wr(`VTCF_VT_UNTAG, 32'h03);
    frm(3'h2, 1'b0, 12'h0, BC, M0, 1'b0, 12'h005, 8'h0B, 8'h03, 8'h08);
    frm(3'h1, 1'b1, 12'h005, BC, M1, 1'b0, 12'h005, 8'h0D, 8'h01, 8'h0C);
    frm(3'h0, 1'b1, 12'h005, M1, M0, 1'b0, 12'h005, 8'h02, 8'h02, 8'h00);
    frm(3'h6, 1'b0, 12'h005, BC, M2, 1'b1, 12'h005, 8'hBF, 8'h00, 8'h00);
    rdc(`VTCF_VT_MEMBER, 32'h4F);
    rdc(`VTCF_VT_UNTAG, 32'h03);
    wr(`VTCF_RT_SEL, 32'h2);
    wr(`VTCF_RT_NET, 32'hC0A80100);
    rdc(`VTCF_RT_NET, 32'hC0A80100);
    // join to an unknown vlan takes the lowest empty slot
    frm(3'h3, 1'b1, 12'h007, BC, M2, 1'b1, 12'h007, 8'hF7, 8'h00, 8'h00);
    wr(`VTCF_VT_SEL, 32'h2);
    rdc(`VTCF_VT_VID, 32'h1007);
    rdc(`VTCF_VT_MEMBER, 32'h08);
    rdc(`VTCF_VT_UNTAG, 32'h00);
    wr(`VTCF_VT_SEL, 32'h1);
    wr(`VTCF_CTRL, 32'h1);
    i_sta.send(3'h7, 1'b0, 12'h005, BC, M2, 1'b1);
    rdc(`VTCF_STATUS, 32'h0301);
    rdc(`VTCF_VT_MEMBER, 32'h4F);
    // member write overlapping other vlans in multilayer mode
    wr(`VTCF_STATUS, 32'h1);
    rdc(`VTCF_STATUS, 32'h0300);
    wr(`VTCF_VT_MEMBER, 32'hCF);
    rdc(`VTCF_VT_MEMBER, 32'h00);
    rdc(`VTCF_STATUS, 32'h0301);
    final_report();
  end
endmodule
`default_nettype wire
